/* File: nvc_pkg.sv */
// package: map, fields, commands and timing of the on-chip flash controller
package nvc_pkg;
	localparam int unsigned CLK_HZ = 50_000_000;
	localparam int unsigned ERASE_HOLD_MS = 220;
	localparam int unsigned ERASE_HOLD_CYC = CLK_HZ / 1000 * ERASE_HOLD_MS;
	localparam int unsigned PLANES = 2;
	localparam int unsigned PLANE_PAGES = 1024;
	localparam int unsigned PAGE_BYTES = 256;
	localparam int unsigned REGION_PAGES = 64;
	// register byte offsets; bit 8 selects the write buffer window
	localparam logic [8:0] OFS_CTRL = 9'h000;
	localparam logic [8:0] OFS_CMD = 9'h004;
	localparam logic [8:0] OFS_STAT = 9'h008;
	localparam logic [8:0] OFS_LOCK = 9'h00C;
	localparam logic [8:0] OFS_CALIB = 9'h010;
	localparam int WBUF_SEL_BIT = 8;
	localparam int CTRL_DONE_IE = 0;
	localparam int CTRL_ERR_IE = 1;
	localparam int CTRL_WS_LSB = 8;
	localparam int CTRL_PT_LSB = 16;
	localparam int CMD_ARG_LSB = 16;
	localparam int STAT_READY = 0;
	localparam int STAT_DONE = 1;
	localparam int STAT_LOCKE = 2;
	localparam int STAT_CMDE = 3;
	localparam int STAT_SEC = 4;
	localparam int STAT_FPM = 5;
	localparam int STAT_GP_LSB = 8;
	localparam logic [31:0] CTRL_RESET = 32'h0004_0100;
	// arbitrary factory calibration pattern
	localparam logic [15:0] CALIB_FACTORY = 16'h0000;
	localparam logic [11:0] MAP_ALIAS = 12'h000;
	localparam logic [11:0] MAP_FLASH = 12'h001;
	localparam logic [11:0] MAP_SRAM = 12'h002;
	localparam logic [11:0] MAP_ROM = 12'h003;
	localparam logic [3:0] CMD_PAGE_PROG = 4'h1;
	localparam logic [3:0] CMD_SET_LOCK = 4'h2;
	localparam logic [3:0] CMD_CLR_LOCK = 4'h3;
	localparam logic [3:0] CMD_ERASE_ALL = 4'h4;
	localparam logic [3:0] CMD_SET_GP = 4'h5;
	localparam logic [3:0] CMD_CLR_GP = 4'h6;
	localparam logic [3:0] CMD_SET_SEC = 4'h7;
	localparam logic [3:0] CMD_ERASE_PAGE = 4'h8;
	localparam logic [3:0] CMD_READ = 4'h9;
	localparam logic [3:0] CMD_WBUF = 4'hA;
	typedef enum logic [1:0] {RGN_ROM, RGN_FLASH, RGN_SRAM, RGN_ABORT} nvc_region_t;
	typedef enum logic [1:0] {S_IDLE, S_WAIT, S_RUN} nvc_state_t;
endpackage

/* File: nvc_flash_ctrl.sv */
// on-chip flash controller: registers, command engine, fetch path, pins
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - largest variant: two planes of 1024 pages of 256 bytes, read as words
// - 256-byte page write buffer filled through 32-bit accesses before programming
// - smallest variant: one plane of 256 pages of 128 bytes, 128-byte buffer
// - software sets wait states and program time; fetch-path flash reads use the wait states, port reads do not
// - full erase, page erase, program, bit set/clear commands; status readable
// - enabled interrupt on command end and on command error
// - two 32-bit prefetch entries serve sequential halfword fetches without flash access
// - each plane busy on its own for page commands; other plane stays readable; full erase busies both
// - largest variant: 32 lock bits, each over 64 pages of 256 bytes
// - smallest variant: 8 lock bits, each over 32 pages of 128 bytes
// - erase or program into locked region aborts untouched and flags an error
// - set-lock protects a region, clear-lock removes it; bits are nonvolatile
// - valid erase pin clears all lock bits
// - security bit refuses all debug probe and fast port accesses
// - security set only by its command; cleared by erase pin plus full erase
// - nvm bit 0 enables brownout detector; erase pin clears it
// - nvm bit 1 enables brownout reset; erase pin clears it
// - sixteen calibration bits fixed, untouched by commands and erase pin
// - fast programming mode only with test pin, lines 0,1 high, line 2 low
// - fast port offers read, program, page erase, full erase, lock, unlock, protect
// - address 0 aliases rom or flash by nvm bit 2; sram after remap
// - flash, sram, rom windows at 1, 2, 3 MB; anything above aborts
// - erase pin debounced; only a level held 220 ms takes effect
module nvc_flash_ctrl #(
	parameter int unsigned PLANES = nvc_pkg::PLANES,
	parameter int unsigned PLANE_PAGES = nvc_pkg::PLANE_PAGES,
	parameter int unsigned PAGE_BYTES = nvc_pkg::PAGE_BYTES,
	parameter int unsigned REGION_PAGES = nvc_pkg::REGION_PAGES,
	parameter int unsigned ERASE_CYC = nvc_pkg::ERASE_HOLD_CYC,
	parameter logic [15:0] CALIB = nvc_pkg::CALIB_FACTORY
) (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic reset_i,
	// wishbone register slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [31:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic wb_err_o,
	// master fetch path
	input wire logic fetch_req_i,
	input wire logic [31:0] fetch_addr_i,
	input wire logic remap_i,
	output logic fetch_ack_o,
	output logic fetch_abort_o,
	output nvc_pkg::nvc_region_t fetch_region_o,
	output logic [31:0] fetch_data_o,
	// debug probe and fast programming port
	input wire logic ext_req_i,
	input wire logic ext_debug_i,
	input wire logic [3:0] ext_cmd_i,
	input wire logic [31:0] ext_arg_i,
	input wire logic [31:0] ext_wdata_i,
	output logic ext_ack_o,
	output logic ext_refused_o,
	output logic [31:0] ext_rdata_o,
	// pins
	input wire logic erase_pin_i,
	input wire logic test_mode_pin_i,
	input wire logic mode_select_line_0_i,
	input wire logic mode_select_line_1_i,
	input wire logic mode_select_line_2_i,
	// status outputs
	output logic irq_o,
	output logic fast_prog_mode_o,
	output logic brownout_detector_enable_o,
	output logic brownout_reset_enable_o,
	output logic [15:0] calib_o
);
	import nvc_pkg::*;

	localparam int unsigned WB_WORDS = PAGE_BYTES / 4;
	localparam int unsigned WORDS = PLANES * PLANE_PAGES * WB_WORDS;
	localparam int unsigned REGIONS = PLANES * PLANE_PAGES / REGION_PAGES;
	localparam int AW = $clog2(WORDS);
	localparam int BW = $clog2(WB_WORDS);
	localparam int PGW = $clog2(PLANES * PLANE_PAGES);
	localparam int RW = $clog2(REGIONS);
	localparam int RSH = $clog2(REGION_PAGES);
	localparam int PSH = $clog2(PLANE_PAGES * WB_WORDS);
	localparam int ECW = $clog2(ERASE_CYC + 1);

	logic [31:0] mem [WORDS];
	logic [31:0] ctrl_q;
	logic [REGIONS-1:0] lock;
	logic [2:0] gp;
	logic sec, armed, pend_erase;
	logic done_f, locke_f, cmde_f;
	logic [ECW-1:0] ecnt;
	nvc_state_t st;
	logic [3:0] cmd_q;
	logic [31:0] arg_q;
	logic [AW-1:0] base, idx, last;
	logic [7:0] tmr;
	logic [PLANES-1:0] busy_pl;
	logic f_busy, f_pf, pvic;
	logic [3:0] f_cnt;
	logic [AW-1:0] f_addr;
	logic [1:0] pv;
	logic [AW-1:0] ptag [2];
	logic [31:0] pdat [2];

	function automatic int plane_of(input logic [AW-1:0] a);
		return int'(a >> PSH);
	endfunction

	// bus decode
	wire [8:0] adr = {wb_adr_i[8:2], 2'b00};
	wire wb_hit = wb_cyc_i & wb_stb_i & !wb_ack_o & !wb_err_o;
	wire in_wbuf = adr[WBUF_SEL_BIT] & (int'(adr[7:2]) < int'(WB_WORDS));
	wire mapped = in_wbuf | adr == OFS_CTRL | adr == OFS_CMD | adr == OFS_STAT
		| adr == OFS_LOCK | adr == OFS_CALIB;
	wire wcmd = wb_hit & wb_we_i & adr == OFS_CMD;
	wire ctrl_wr = wb_hit & wb_we_i & adr == OFS_CTRL;
	wire stat_rd = wb_hit & !wb_we_i & adr == OFS_STAT;
	wire wb_wbuf_wr = wb_hit & wb_we_i & in_wbuf;
	wire [BW-1:0] wb_bidx = wb_adr_i[BW+1:2];
	wire [3:0] ws = ctrl_q[CTRL_WS_LSB +: 4];
	wire [7:0] prog_t = ctrl_q[CTRL_PT_LSB +: 8];
	wire idle = st == S_IDLE;

	// external port decode
	wire ext_take = ext_req_i & !ext_ack_o;
	wire ext_is_eng = ext_cmd_i != CMD_READ & ext_cmd_i != CMD_WBUF;
	wire ext_ref = sec | (!ext_debug_i & !fast_prog_mode_o)
		| (ext_is_eng & (!idle | wcmd | pend_erase))
		| (ext_cmd_i == CMD_WBUF & wb_wbuf_wr);
	wire ext_ok = ext_take & !ext_ref;
	wire ext_wbuf_wr = ext_ok & ext_cmd_i == CMD_WBUF;

	// command start
	wire [3:0] req_cmd = wcmd ? wb_dat_i[3:0] : ext_cmd_i;
	wire [31:0] req_arg = wcmd ? {16'h0000, wb_dat_i[CMD_ARG_LSB +: 16]} : ext_arg_i;
	wire cmd_valid = req_cmd >= CMD_PAGE_PROG & req_cmd <= CMD_ERASE_PAGE;
	wire req_go = wcmd | (ext_ok & ext_is_eng);
	wire go_pin = pend_erase & idle;
	wire go_sw = req_go & idle & !pend_erase & cmd_valid;
	wire go = go_pin | go_sw;
	wire [3:0] gcmd = go_pin ? CMD_ERASE_ALL : req_cmd;
	wire [PGW-1:0] g_pg = req_arg[PGW-1:0];
	wire [RW-1:0] g_rgn = RW'(g_pg >> RSH);
	wire g_page_op = gcmd == CMD_PAGE_PROG | gcmd == CMD_ERASE_PAGE;
	wire lock_hit = go_sw & ((g_page_op & lock[g_rgn])
		| (gcmd == CMD_ERASE_ALL & |lock));
	wire cmd_err = wcmd & !go_sw;
	wire q_mem = cmd_q == CMD_PAGE_PROG | cmd_q == CMD_ERASE_PAGE | cmd_q == CMD_ERASE_ALL;
	wire [AW-1:0] waddr = base + idx;
	wire nvm_apply = st == S_WAIT & tmr == 8'h00 & !q_mem;
	wire cmd_end = nvm_apply | (st == S_RUN & waddr == last);
	wire [RW-1:0] q_rgn = RW'(arg_q[PGW-1:0] >> RSH);
	wire pin_fire = erase_pin_i & ecnt == ECW'(ERASE_CYC - 1);

	// write buffer, one byte lane per loop pass
	logic [31:0] wbuf_bus, wbuf_eng;
	for (genvar l = 0; l < 4; l++) begin : g_lane
		logic [7:0] lane_mem [WB_WORDS];
		always_ff @(posedge ref_clk_i) begin
			if (wb_wbuf_wr & wb_sel_i[l]) begin
				lane_mem[wb_bidx] <= wb_dat_i[8*l +: 8];
			end else if (ext_wbuf_wr) begin
				lane_mem[ext_arg_i[BW-1:0]] <= ext_wdata_i[8*l +: 8];
			end
		end
		assign wbuf_bus[8*l +: 8] = lane_mem[wb_bidx];
		assign wbuf_eng[8*l +: 8] = lane_mem[idx[BW-1:0]];
	end

	// a plane is busy while its own page is worked on; a full erase keeps both planes busy
	for (genvar p = 0; p < PLANES; p++) begin : g_plane
		assign busy_pl[p] = !idle & (cmd_q == CMD_ERASE_ALL | plane_of(base) == p);
	end

	logic [31:0] stat_w;
	always_comb begin
		stat_w = 32'h0000_0000;
		stat_w[STAT_READY] = idle & !pend_erase;
		stat_w[STAT_DONE] = done_f;
		stat_w[STAT_LOCKE] = locke_f;
		stat_w[STAT_CMDE] = cmde_f;
		stat_w[STAT_SEC] = sec;
		stat_w[STAT_FPM] = fast_prog_mode_o;
		stat_w[STAT_GP_LSB +: 3] = gp;
	end

	wire [31:0] rd_word = in_wbuf ? wbuf_bus : adr == OFS_CTRL ? ctrl_q
		: adr == OFS_STAT ? stat_w : adr == OFS_LOCK ? 32'(lock)
		: adr == OFS_CALIB ? {16'h0000, calib_o} : 32'h0000_0000;

	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			wb_ack_o <= 1'b0;
			wb_err_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
			ctrl_q <= CTRL_RESET;
		end else begin
			wb_ack_o <= wb_hit & mapped;
			wb_err_o <= wb_hit & !mapped;
			wb_dat_o <= wb_hit & !wb_we_i ? rd_word : 32'h0000_0000;
			if (ctrl_wr) begin
				ctrl_q <= wb_dat_i;
			end
		end
	end

	// sticky flags: a new event beats the read that clears them
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			done_f <= 1'b0;
			locke_f <= 1'b0;
			cmde_f <= 1'b0;
			irq_o <= 1'b0;
		end else begin
			done_f <= cmd_end | lock_hit | (done_f & !stat_rd);
			locke_f <= lock_hit | (locke_f & !stat_rd);
			cmde_f <= cmd_err | (cmde_f & !stat_rd);
			irq_o <= (done_f & ctrl_q[CTRL_DONE_IE])
				| ((locke_f | cmde_f) & ctrl_q[CTRL_ERR_IE]);
		end
	end

	// command engine
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			st <= S_IDLE;
			cmd_q <= 4'h0;
			arg_q <= 32'h0000_0000;
			base <= '0;
			last <= '0;
			idx <= '0;
			tmr <= 8'h00;
		end else begin
			case (st)
				S_IDLE: begin
					if (go & !lock_hit) begin
						st <= S_WAIT;
						cmd_q <= gcmd;
						arg_q <= req_arg;
						tmr <= prog_t;
						idx <= '0;
						base <= gcmd == CMD_ERASE_ALL ? '0 : AW'(g_pg) << BW;
						last <= gcmd == CMD_ERASE_ALL ? AW'(WORDS - 1)
							: (AW'(g_pg) << BW) + AW'(WB_WORDS - 1);
					end
				end
				S_WAIT: begin
					if (tmr != 8'h00) begin
						tmr <= tmr - 8'h01;
					end else begin
						st <= q_mem ? S_RUN : S_IDLE;
					end
				end
				S_RUN: begin
					idx <= idx + AW'(1);
					if (waddr == last) begin
						st <= S_IDLE;
					end
				end
				default: st <= S_IDLE;
			endcase
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (st == S_RUN) begin
			mem[waddr] <= cmd_q == CMD_PAGE_PROG ? wbuf_eng : 32'hFFFF_FFFF;
		end
	end

	// nonvolatile bits; reset stands for a blank part at power-up
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			lock <= '0;
			gp <= 3'h0;
			sec <= 1'b0;
			armed <= 1'b0;
			pend_erase <= 1'b0;
			ecnt <= '0;
		end else begin
			ecnt <= !erase_pin_i ? '0 : ecnt == ECW'(ERASE_CYC) ? ecnt : ecnt + ECW'(1);
			if (pin_fire) begin
				lock <= '0;
				gp[1:0] <= 2'b00;
				armed <= 1'b1;
				pend_erase <= 1'b1;
			end else begin
				if (go_pin) begin
					pend_erase <= 1'b0;
				end
				if (nvm_apply) begin
					case (cmd_q)
						CMD_SET_LOCK: lock[q_rgn] <= 1'b1;
						CMD_CLR_LOCK: lock[q_rgn] <= 1'b0;
						CMD_SET_GP: if (arg_q[1:0] != 2'b11) gp[arg_q[1:0]] <= 1'b1;
						CMD_CLR_GP: if (arg_q[1:0] != 2'b11) gp[arg_q[1:0]] <= 1'b0;
						CMD_SET_SEC: sec <= 1'b1;
						default: ;
					endcase
				end
				if (cmd_end & cmd_q == CMD_ERASE_ALL & armed) begin
					sec <= 1'b0;
					armed <= 1'b0;
				end
			end
		end
	end

	// pins and fixed outputs
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			fast_prog_mode_o <= 1'b0;
			brownout_detector_enable_o <= 1'b0;
			brownout_reset_enable_o <= 1'b0;
			calib_o <= CALIB;
			ext_ack_o <= 1'b0;
			ext_refused_o <= 1'b0;
			ext_rdata_o <= 32'h0000_0000;
		end else begin
			fast_prog_mode_o <= test_mode_pin_i & mode_select_line_0_i
				& mode_select_line_1_i & !mode_select_line_2_i;
			brownout_detector_enable_o <= gp[0];
			brownout_reset_enable_o <= gp[1];
			calib_o <= CALIB;
			ext_ack_o <= ext_take;
			ext_refused_o <= ext_take & ext_ref;
			if (ext_ok & ext_cmd_i == CMD_READ) begin
				ext_rdata_o <= mem[ext_arg_i[AW-1:0]];
			end
		end
	end

	// fetch path: region decode and two-entry prefetch
	wire [11:0] top = fetch_addr_i[31:20];
	nvc_region_t rgn;
	assign rgn = top == MAP_ALIAS ? (remap_i ? RGN_SRAM : gp[2] ? RGN_FLASH : RGN_ROM)
		: top == MAP_FLASH ? RGN_FLASH : top == MAP_SRAM ? RGN_SRAM
		: top == MAP_ROM ? RGN_ROM : RGN_ABORT;
	wire [AW-1:0] fw = fetch_addr_i[AW+1:2];
	wire h0 = pv[0] & ptag[0] == fw;
	wire h1 = pv[1] & ptag[1] == fw;
	wire f_new = fetch_req_i & !fetch_ack_o;
	wire f_hit = f_new & rgn == RGN_FLASH & (h0 | h1);
	wire f_other = f_new & rgn != RGN_FLASH;
	wire f_miss = f_new & rgn == RGN_FLASH & !h0 & !h1 & !f_busy;
	wire f_fill = f_busy & f_cnt == 4'h0 & !busy_pl[plane_of(f_addr)];

	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			fetch_ack_o <= 1'b0;
			fetch_abort_o <= 1'b0;
			fetch_region_o <= RGN_ROM;
			fetch_data_o <= 32'h0000_0000;
			f_busy <= 1'b0;
			f_pf <= 1'b0;
			f_cnt <= 4'h0;
			f_addr <= '0;
			pv <= 2'b00;
			pvic <= 1'b0;
			ptag <= '{default: '0};
			pdat <= '{default: '0};
		end else begin
			fetch_ack_o <= f_hit | f_other | (f_fill & !f_pf);
			if (f_hit | f_other) begin
				fetch_abort_o <= rgn == RGN_ABORT;
				fetch_region_o <= rgn;
				fetch_data_o <= f_hit ? (h0 ? pdat[0] : pdat[1]) : 32'h0000_0000;
			end
			if (f_miss) begin
				f_busy <= 1'b1;
				f_pf <= 1'b0;
				f_addr <= fw;
				f_cnt <= ws;
			end else if (f_busy & f_cnt != 4'h0) begin
				f_cnt <= f_cnt - 4'h1;
			end else if (f_fill) begin
				pdat[pvic] <= mem[f_addr];
				ptag[pvic] <= f_addr;
				pv[pvic] <= 1'b1;
				pvic <= !pvic;
				if (!f_pf) begin
					fetch_abort_o <= 1'b0;
					fetch_region_o <= RGN_FLASH;
					fetch_data_o <= mem[f_addr];
					f_pf <= 1'b1; // fetch the next word ahead
					f_addr <= f_addr + AW'(1);
					f_cnt <= ws;
				end else begin
					f_busy <= 1'b0;
				end
			end
			if (st == S_RUN) begin
				pv <= 2'b00; // stale after any array write
			end
		end
	end

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (reset_i);

	a_lock_abort: assert property (lock_hit |=> idle && locke_f)
		else $error("locked command not aborted");
	a_busy_refuse: assert property (wcmd && !idle |=> cmde_f && $stable(arg_q))
		else $error("command taken while busy");
	a_sec_block: assert property (ext_take && sec |=> ext_ack_o && ext_refused_o)
		else $error("secured access not refused");
	a_pin_clear: assert property (pin_fire |=> lock == '0 && gp[1:0] == 2'b00 ##1 !brownout_detector_enable_o)
		else $error("erase pin did not clear bits");
	a_fpm_entry: assert property (fast_prog_mode_o |-> $past(test_mode_pin_i) && !$past(mode_select_line_2_i))
		else $error("fast mode without strap");
	a_hit_quick: assert property (f_hit |=> fetch_ack_o && fetch_region_o == RGN_FLASH)
		else $error("prefetch hit not served");
	a_map_abort: assert property (f_new && rgn == RGN_ABORT |=> fetch_ack_o && fetch_abort_o)
		else $error("undefined area not aborted");
	a_wait_state: assert property (f_miss && ws != 4'h0 |=> !fetch_ack_o [*2])
		else $error("wait states skipped");
	a_boot_alias: assert property (f_other && top == MAP_ALIAS && !remap_i && !gp[2]
		|=> fetch_region_o == RGN_ROM)
		else $error("boot alias wrong");
	a_short_erase: assert property (!erase_pin_i |=> ecnt == '0 && !pin_fire)
		else $error("erase debounce not reset");

	c_lock_abort: cover property (lock_hit);
	c_prefetch_hit: cover property (f_fill && f_pf ##[1:20] f_hit);
	c_pin_erase: cover property (go_pin ##[1:8] !idle);
	c_cmd_end: cover property (cmd_end && cmd_q == CMD_PAGE_PROG);
endmodule

`default_nettype wire

/* File: nvc_prog_model.sv */
// external programmer model: drives the debug/fast port and the mode and erase pins
`timescale 1ns/1ps
`default_nettype none
module nvc_prog_model (
	// clock
	input wire logic clk_i,
	// answer from the controller
	input wire logic ack_i,
	input wire logic refused_i,
	input wire logic [31:0] rdata_i,
	// request to the controller
	output logic req_o,
	output logic debug_o,
	output logic [3:0] cmd_o,
	output logic [31:0] arg_o,
	output logic [31:0] wdata_o,
	// pins: erase, then {test, line 2, line 1, line 0}
	output logic erase_o,
	output logic [3:0] mode_o
);
	initial begin
		req_o = 1'b0;
		debug_o = 1'b0;
		cmd_o = 4'h0;
		arg_o = 32'h0000_0000;
		wdata_o = 32'h0000_0000;
		erase_o = 1'b0;
		mode_o = 4'h0;
	end

	// request held until ack is seen; released lines show the inverse, not a stale copy
	// buffer word writes carry the inverted index as data
	task automatic xfer(input logic dbg, input logic [3:0] c, input logic [31:0] a,
		output logic [31:0] q, output logic r);
		@(posedge clk_i);
		req_o <= 1'b1;
		debug_o <= dbg;
		cmd_o <= c;
		arg_o <= a;
		wdata_o <= ~a;
		do begin
			@(posedge clk_i);
		end while (ack_i !== 1'b1);
		q = rdata_i;
		r = refused_i;
		req_o <= 1'b0;
		cmd_o <= ~c;
		arg_o <= ~a;
		wdata_o <= a;
	endtask

	task automatic set_mode(input logic [3:0] m);
		@(posedge clk_i);
		mode_o <= m;
	endtask

	// a real reinitialisation is held past the debounce limit
	task automatic erase_pulse(input int cyc);
		@(posedge clk_i);
		erase_o <= 1'b1;
		repeat (cyc) @(posedge clk_i);
		erase_o <= 1'b0;
	endtask
endmodule
`default_nettype wire

/* File: embedded_flash_controller_tb_top.sv */
// self-checking bench for the on-chip flash controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_errors++; $display("unexpected %s exp %h got %h", nm, e, g); end end
module embedded_flash_controller_tb_top;
	import nvc_pkg::*;
	// fewer pages so a full erase fits the run
	localparam int unsigned PP = 128;
	localparam int unsigned EC = 20;
	localparam int unsigned WPP = PAGE_BYTES / 4;
	localparam logic [31:0] FB = 32'h0010_0000;
	localparam logic [31:0] PB = PP * PAGE_BYTES;
	localparam int HIT = 2;
	logic clk, rst, cyc, stb, we, ack, err, last_err, freq, remap, fack, fabort, erq, edbg, eack, eref, erase, irq;
	logic fpm, brownout_detector, bor, er;
	logic [3:0] ecmd, mode, sel, wsel;
	logic [31:0] adr, dat, wq, faddr, fdata, earg, ewd, erd, q, st, eq;
	logic [15:0] calib;
	nvc_region_t freg;
	int n_errors = 0, num_checks = 0, n, m, tick = 0;
	logic [31:0] ra [5] = '{32'h0000_0000, 32'h0000_0000, 32'h0020_0000, 32'h0030_0000, 32'h0040_0000};
	logic rm [5] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
	nvc_region_t rr [5] = '{RGN_ROM, RGN_SRAM, RGN_SRAM, RGN_ROM, RGN_ABORT};

	nvc_flash_ctrl #(.PLANE_PAGES(PP), .ERASE_CYC(EC)) DUT (.ref_clk_i(clk), .reset_i(rst), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wq),
		.wb_ack_o(ack), .wb_err_o(err), .fetch_req_i(freq), .fetch_addr_i(faddr), .remap_i(remap),
		.fetch_ack_o(fack), .fetch_abort_o(fabort), .fetch_region_o(freg), .fetch_data_o(fdata),
		.ext_req_i(erq), .ext_debug_i(edbg), .ext_cmd_i(ecmd), .ext_arg_i(earg), .ext_wdata_i(ewd),
		.ext_ack_o(eack), .ext_refused_o(eref), .ext_rdata_o(erd), .erase_pin_i(erase),
		.test_mode_pin_i(mode[3]), .mode_select_line_2_i(mode[2]), .mode_select_line_1_i(mode[1]),
		.mode_select_line_0_i(mode[0]), .irq_o(irq), .fast_prog_mode_o(fpm),
		.brownout_detector_enable_o(brownout_detector), .brownout_reset_enable_o(bor), .calib_o(calib));
	nvc_prog_model pm (.clk_i(clk), .ack_i(eack), .refused_i(eref), .rdata_i(erd), .req_o(erq), .debug_o(edbg),
		.cmd_o(ecmd), .arg_o(earg), .wdata_o(ewd), .erase_o(erase), .mode_o(mode));

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	task automatic stop_test;
		$display("checks %0d mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	always @(posedge clk) begin
		tick <= tick + 1;
		if (tick == 60000) begin
			n_errors++;
			stop_test();
		end
	end

	task automatic wb(input logic w, input logic [8:0] a, input logic [31:0] d, output logic [31:0] r);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {23'h00_0000, a};
		sel <= wsel;
		dat <= d;
		do begin
			@(posedge clk);
		end while (ack !== 1'b1 && err !== 1'b1);
		r = wq;
		last_err = err;
		cyc <= 1'b0;
		stb <= 1'b0;
		sel <= ~wsel;
		dat <= ~d;
	endtask

	task automatic fetch(input logic [31:0] a, output int k);
		k = 0;
		@(posedge clk);
		freq <= 1'b1;
		faddr <= a;
		do begin
			@(posedge clk);
			k++;
		end while (fack !== 1'b1);
		freq <= 1'b0;
	endtask

	task automatic cmd(input logic [3:0] c, input logic [15:0] p);
		wb(1'b1, OFS_CMD, {p, 12'h000, c}, q);
	endtask

	// the status read also clears the flags behind the interrupt
	task automatic wait_irq;
		while (irq !== 1'b1) begin
			@(negedge clk);
		end
		wb(1'b0, OFS_STAT, 32'h0000_0000, st);
	endtask

	task automatic do_cmd(input logic [3:0] c, input logic [15:0] p);
		cmd(c, p);
		wait_irq();
	endtask

	initial begin
		rst = 1'b1;
		{cyc, stb, we, freq, remap} = 5'h00;
		{sel, wsel} = 8'h0F;
		{adr, dat, faddr} = 96'h0;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		wb(1'b0, OFS_CTRL, 32'h0000_0000, q); `CHK("ctrl", CTRL_RESET, q)
		`CHK("calib_o", CALIB_FACTORY, calib)
		wb(1'b1, OFS_CALIB, 32'h0000_FFFF, q);
		wb(1'b0, OFS_CALIB, 32'h0000_0000, q); `CHK("calib", CALIB_FACTORY, q[15:0])
		wb(1'b0, 9'h014, 32'h0000_0000, q); `CHK("unmapped", 1'b1, last_err)
		wb(1'b0, OFS_STAT, 32'h0000_0000, q); `CHK("ready", 1'b1, q[STAT_READY])
		$display("test reset done");
		wb(1'b1, OFS_CTRL, 32'h0002_0003, q);
		for (int i = 0; i < WPP; i++) wb(1'b1, 9'h100 + 9'(4 * i), 32'hA5A5_0000 + 32'(i), q);
		wsel = 4'h3;
		wb(1'b1, 9'h1FC, 32'h0000_FFFF, q);
		wsel = 4'hF;
		fetch(FB + PB + 32'h0000_0100, m);
		cmd(CMD_PAGE_PROG, 16'h0005);
		fetch(FB + PB + 32'h0000_0200, n); `CHK("plane b", m, n)
		cmd(CMD_SET_GP, 16'h0000);
		wb(1'b0, OFS_STAT, 32'h0000_0000, q); `CHK("busy", 2'b10, {q[STAT_CMDE], q[STAT_READY]})
		repeat (3) @(negedge clk);
		`CHK("irq cleared", 1'b0, irq)
		wait_irq(); `CHK("done", 2'b11, {st[STAT_DONE], st[STAT_READY]})
		do_cmd(4'hF, 16'h0000); `CHK("bad code", 1'b1, st[STAT_CMDE])
		do_cmd(CMD_ERASE_PAGE, 16'h0006);
		pm.xfer(1'b1, CMD_READ, 32'h0000_0180, eq, er); `CHK("page erased", 32'hFFFF_FFFF, eq)
		pm.xfer(1'b1, CMD_READ, 32'h0000_017F, eq, er); `CHK("last word", 32'hA5A5_FFFF, eq)
		pm.xfer(1'b1, CMD_WBUF, 32'h0000_0002, eq, er);
		wb(1'b0, 9'h108, 32'h0000_0000, q); `CHK("ext wbuf", 32'hFFFF_FFFD, q)
		$display("test program done");
		fetch(FB + 32'h0000_0500, m); `CHK("fetch", 32'hA5A5_0000, fdata)
		repeat (8) @(posedge clk);
		fetch(FB + 32'h0000_0502, n); `CHK("half hit", HIT, n)
		fetch(FB + 32'h0000_0504, n); `CHK("next hit", HIT, n)
		`CHK("next word", 32'hA5A5_0001, fdata)
		wb(1'b1, OFS_CTRL, 32'h0002_0303, q);
		fetch(FB + 32'h0000_0600, n); `CHK("wait states", m + 3, n)
		for (int i = 0; i < 5; i++) begin
			@(posedge clk);
			remap <= rm[i];
			fetch(ra[i], n); `CHK("region", rr[i], freg)
			`CHK("abort", i == 4, fabort)
		end
		$display("test map done");
		do_cmd(CMD_SET_LOCK, 16'h0005);
		do_cmd(CMD_SET_LOCK, 16'h0046);
		wb(1'b0, OFS_LOCK, 32'h0000_0000, q); `CHK("locks", 2'b11, q[1:0])
		do_cmd(CMD_PAGE_PROG, 16'h0005); `CHK("lock err", 1'b1, st[STAT_LOCKE])
		do_cmd(CMD_ERASE_ALL, 16'h0000); `CHK("lock err all", 1'b1, st[STAT_LOCKE])
		pm.xfer(1'b1, CMD_READ, 32'h0000_0140, eq, er); `CHK("untouched", 32'hA5A5_0000, eq)
		do_cmd(CMD_CLR_LOCK, 16'h0005);
		wb(1'b0, OFS_LOCK, 32'h0000_0000, q); `CHK("unlock", 2'b10, q[1:0])
		$display("test lock done");
		for (int b = 0; b < 3; b++) do_cmd(CMD_SET_GP, 16'(b));
		`CHK("nvm bits", 3'b111, st[STAT_GP_LSB+:3])
		`CHK("bod", 2'b11, {brownout_detector, bor})
		do_cmd(CMD_CLR_GP, 16'h0001); `CHK("bor off", 1'b0, bor)
		do_cmd(CMD_SET_GP, 16'h0001);
		@(posedge clk);
		remap <= 1'b0;
		fetch(32'h0000_0000, n); `CHK("boot flash", RGN_FLASH, freg)
		$display("test nvm done");
		pm.set_mode(4'b1011);
		repeat (3) @(negedge clk);
		`CHK("fast mode", 1'b1, fpm)
		pm.xfer(1'b0, CMD_READ, 32'h0000_0141, eq, er); `CHK("fast read", 33'h0_A5A5_0001, {er, eq})
		pm.set_mode(4'b1111);
		repeat (3) @(negedge clk);
		`CHK("no fast mode", 1'b0, fpm)
		pm.set_mode(4'b1011);
		do_cmd(CMD_SET_SEC, 16'h0000); `CHK("sec", 1'b1, st[STAT_SEC])
		pm.xfer(1'b1, CMD_READ, 32'h0000_0140, eq, er); `CHK("probe refused", 1'b1, er)
		pm.xfer(1'b0, CMD_READ, 32'h0000_0140, eq, er); `CHK("fast refused", 1'b1, er)
		pm.set_mode(4'b0000);
		$display("test security done");
		pm.erase_pulse(EC / 2);
		repeat (5) @(negedge clk);
		`CHK("short erase", 1'b1, brownout_detector)
		pm.erase_pulse(EC + 5);
		st = 32'h0000_0000;
		while (st[STAT_READY] !== 1'b1) wb(1'b0, OFS_STAT, 32'h0000_0000, st);
		`CHK("sec cleared", 1'b0, st[STAT_SEC])
		`CHK("bod cleared", 2'b00, {brownout_detector, bor})
		`CHK("calib kept", CALIB_FACTORY, calib)
		wb(1'b0, OFS_LOCK, 32'h0000_0000, q); `CHK("locks cleared", 32'h0000_0000, q)
		pm.xfer(1'b1, CMD_READ, 32'h0000_0140, eq, er); `CHK("wiped", 33'h0_FFFF_FFFF, {er, eq})
		$display("test erase pin done");
		stop_test();
	end
endmodule
`default_nettype wire
